// >>> hdl/asw_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "asw_sram_map.svh"
module asw_host
    import asw_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // user request
    input wire logic req_i,
    input wire logic req_wr_i,
    input wire logic [ASW_AW-1:0] req_addr_i,
    input wire logic [ASW_DW-1:0] req_wdata_i,
    output logic busy_o,
    output logic done_o,
    output logic [ASW_DW-1:0] rdata_o,
    // memory pins
    output logic sel_low_active_n_o,
    output logic sel_high_active_o,
    output logic wr_strobe_n_o,
    output logic out_gate_n_o,
    output logic [ASW_AW-1:0] addr_o,
    output logic [ASW_DW-1:0] data_o,
    output logic data_oe_o,
    input wire logic [ASW_DW-1:0] data_i
);
    typedef struct packed {
        asw_state_t st;
        logic wr;
        logic busy;
        logic done;
        logic [ASW_DW-1:0] rdata;
        logic [3:0] lowcnt;
        asw_pins_t pins;
    } asw_reg_t;

    asw_reg_t s_r;
    asw_reg_t s_nxt;
    logic tload;
    logic [3:0] tcount;
    logic tdone;
    logic [ASW_DW-1:0] din_s1_r;
    logic [ASW_DW-1:0] din_s2_r;

    ////////////////////////////////////////////////////////////////////////
    // data pins come from outside, two flops before use
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            din_s1_r <= '0;
            din_s2_r <= '0;
        end else begin
            din_s1_r <= data_i;
            din_s2_r <= din_s1_r;
        end
    end

    asw_timer u_timer (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .load_i(tload),
        .count_i(tcount),
        .done_o(tdone)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer; the strobe alone brackets each write so data timing
    // is always referenced to its rising edge
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        tload = 1'b0;
        tcount = 4'(`ASW_SETUP_CYC);
        // length of the current strobe-low run, watched by the checks
        s_nxt.lowcnt = s_r.pins.wr_n ? `ASW_CNT_ZERO : s_r.lowcnt + 4'h1;
        unique case (s_r.st)
            ASW_IDLE: begin
                if (req_i) begin
                    // address and selects first, strobe still high
                    s_nxt.pins.addr = req_addr_i;
                    s_nxt.pins.sel_n = 1'b0;
                    s_nxt.pins.sel_hi = 1'b1;
                    s_nxt.pins.gate_n = 1'b1;
                    s_nxt.pins.dout = req_wdata_i;
                    s_nxt.pins.doe = req_wr_i;
                    s_nxt.wr = req_wr_i;
                    s_nxt.busy = 1'b1;
                    s_nxt.st = ASW_SETUP;
                    tload = 1'b1;
                end
            end
            ASW_SETUP: begin
                if (tdone) begin
                    tload = 1'b1;
                    if (s_r.wr) begin
                        // strobe goes last, starting the write
                        s_nxt.pins.wr_n = 1'b0;
                        tcount = 4'(`ASW_PULSE_CYC);
                        s_nxt.st = ASW_PULSE;
                    end else begin
                        // gate opens only for a read; the window covers
                        // the access time plus the two-flop lag on data_i
                        s_nxt.pins.gate_n = 1'b0;
                        tcount = 4'(`ASW_READ_CYC + `ASW_SYNC_CYC);
                        s_nxt.st = ASW_READ;
                    end
                end
            end
            ASW_PULSE: begin
                // held a whole count, never toggled inside
                if (tdone) begin
                    s_nxt.pins.wr_n = 1'b1;
                    tload = 1'b1;
                    tcount = 4'(`ASW_HOLD_CYC);
                    s_nxt.st = ASW_HOLD;
                end
            end
            ASW_READ: begin
                if (tdone) begin
                    s_nxt.rdata = din_s2_r;
                    s_nxt.pins.gate_n = 1'b1;
                    tload = 1'b1;
                    tcount = 4'(`ASW_HOLD_CYC);
                    s_nxt.st = ASW_HOLD;
                end
            end
            ASW_HOLD: begin
                // address and data kept until here, past strobe rise
                if (tdone) begin
                    s_nxt.pins.sel_n = 1'b1;
                    s_nxt.pins.sel_hi = 1'b0;
                    s_nxt.pins.doe = 1'b0;
                    s_nxt.busy = 1'b0;
                    s_nxt.done = 1'b1;
                    s_nxt.st = ASW_IDLE;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.st <= ASW_IDLE;
            s_r.pins.sel_n <= 1'b1;
            s_r.pins.wr_n <= 1'b1;
            s_r.pins.gate_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign busy_o = s_r.busy;
    assign done_o = s_r.done;
    assign rdata_o = s_r.rdata;
    assign sel_low_active_n_o = s_r.pins.sel_n;
    assign sel_high_active_o = s_r.pins.sel_hi;
    assign wr_strobe_n_o = s_r.pins.wr_n;
    assign out_gate_n_o = s_r.pins.gate_n;
    assign addr_o = s_r.pins.addr;
    assign data_o = s_r.pins.dout;
    assign data_oe_o = s_r.pins.doe;

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_GATE_HIGH_IN_WRITE: assert property (@(posedge core_clk_i)
        disable iff (rst_i) !wr_strobe_n_o |-> out_gate_n_o)
        else $error("gate low during write");
    AST_ADDR_STABLE: assert property (@(posedge core_clk_i)
        disable iff (rst_i) !wr_strobe_n_o |=> $stable(addr_o))
        else $error("address moved during write");
    AST_STROBE_LAST: assert property (@(posedge core_clk_i)
        disable iff (rst_i) $fell(wr_strobe_n_o) |->
        $past(!sel_low_active_n_o && sel_high_active_o))
        else $error("strobe not last");
    AST_PULSE_WIDTH: assert property (@(posedge core_clk_i)
        disable iff (rst_i) $rose(wr_strobe_n_o) |->
        s_r.lowcnt >= 4'(`ASW_PULSE_CYC))
        else $error("strobe pulse short");
    AST_DATA_HOLD: assert property (@(posedge core_clk_i)
        disable iff (rst_i) $rose(wr_strobe_n_o) |->
        data_oe_o && $stable(data_o))
        else $error("data not held at strobe rise");
    AST_GATE_ONLY_READ: assert property (@(posedge core_clk_i)
        disable iff (rst_i) !out_gate_n_o |-> !data_oe_o &&
        wr_strobe_n_o)
        else $error("gate low outside read");
    AST_SEL_BOTH: assert property (@(posedge core_clk_i)
        disable iff (rst_i) busy_o |-> sel_high_active_o ==
        !sel_low_active_n_o)
        else $error("selects disagree");
    AST_DONE_TIME: assert property (@(posedge core_clk_i)
        disable iff (rst_i) $fell(wr_strobe_n_o) |-> ##[1:4]
        done_o)
        else $error("write never completed");
    COV_WRITE: cover property (@(posedge core_clk_i) $rose(wr_strobe_n_o));
    COV_READ: cover property (@(posedge core_clk_i) $rose(out_gate_n_o));
    COV_B2B: cover property (@(posedge core_clk_i) done_o && req_i);
endmodule
`default_nettype wire

// >>> hdl/asw_pkg.sv
package asw_pkg;
    localparam int ASW_AW = 13;
    localparam int ASW_DW = 8;
    typedef enum logic [4:0] {
        ASW_IDLE = 5'h01,
        ASW_SETUP = 5'h02,
        ASW_PULSE = 5'h04,
        ASW_HOLD = 5'h08,
        ASW_READ = 5'h10
    } asw_state_t;
    // pins driven toward the memory
    typedef struct packed {
        logic sel_n;
        logic sel_hi;
        logic wr_n;
        logic gate_n;
        logic [ASW_AW-1:0] addr;
        logic [ASW_DW-1:0] dout;
        logic doe;
    } asw_pins_t;
endpackage

// >>> hdl/asw_sram_map.svh
`ifndef ASW_SRAM_MAP_SVH
`define ASW_SRAM_MAP_SVH
// bus timing in ns, from the slowest speed grade
`define ASW_CLK_NS 50
`define ASW_SETUP_NS 0
`define ASW_PULSE_NS 50
`define ASW_HOLD_NS 0
`define ASW_READ_NS 70
// cycle counts, least times rounded up, never below one
`define ASW_CYC(ns) ((((ns) + `ASW_CLK_NS - 1) / `ASW_CLK_NS) < 1 ? 1 : \
    (((ns) + `ASW_CLK_NS - 1) / `ASW_CLK_NS))
`define ASW_SETUP_CYC `ASW_CYC(`ASW_SETUP_NS)
`define ASW_PULSE_CYC `ASW_CYC(`ASW_PULSE_NS)
`define ASW_HOLD_CYC `ASW_CYC(`ASW_HOLD_NS)
`define ASW_READ_CYC `ASW_CYC(`ASW_READ_NS)
// flops between the data pins and the read capture
`define ASW_SYNC_CYC 2
`define ASW_CNT_ZERO 4'h0
`endif

// >>> hdl/asw_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "asw_sram_map.svh"
// phase timer: load a count, pulse done when it expires
module asw_timer (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [3:0] count_i,
    output logic done_o
);
    logic [3:0] cnt_r;
    logic run_r;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cnt_r <= `ASW_CNT_ZERO;
            run_r <= 1'b0;
        end else if (load_i) begin
            cnt_r <= count_i - 4'h1;
            run_r <= 1'b1;
        end else if (run_r && cnt_r != `ASW_CNT_ZERO) begin
            cnt_r <= cnt_r - 4'h1;
        end else begin
            run_r <= 1'b0;
        end
    end
    assign done_o = run_r && (cnt_r == `ASW_CNT_ZERO);
endmodule
`default_nettype wire

// >>> tb/asw_sram_model.sv
`timescale 1ns/1ns
`default_nettype none
// behavioural byte-wide static memory on the far side of the host
module asw_sram_model
    import asw_pkg::*;
(
    // control pins
    input wire logic sel_n_i,
    input wire logic sel_hi_i,
    input wire logic wr_n_i,
    input wire logic gate_n_i,
    // address and data
    input wire logic [ASW_AW-1:0] addr_i,
    input wire logic [ASW_DW-1:0] wdata_i,
    output logic [ASW_DW-1:0] rdata_o,
    output logic drv_o
);
    logic [ASW_DW-1:0] mem [0:(1<<ASW_AW)-1];
    logic [ASW_DW-1:0] last_q;
    logic wr_on;
    initial last_q = 8'h00;
    // a write runs only while both selects and the strobe are active
    assign wr_on = !sel_n_i && sel_hi_i && !wr_n_i;
    // store at the closing edge only, so no other word is ever touched
    always @(negedge wr_on) begin
        mem[addr_i] = wdata_i;
    end
    // drive only when selected, gated on and not writing
    assign drv_o = !sel_n_i && sel_hi_i && wr_n_i && !gate_n_i;
    // released pins show the inverse of the last byte, not a stale copy
    always @* begin
        if (drv_o) begin
            rdata_o = mem[addr_i];
            last_q = rdata_o;
        end else begin
            rdata_o = ~last_q;
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import asw_pkg::*;
;
    logic clk, rst, req, req_wr, busy, done, sel_n, sel_hi, wr_n, gate_n;
    logic oe, drv, prev_sel;
    logic [ASW_AW-1:0] req_addr, addr, prev_addr;
    logic [ASW_DW-1:0] req_wdata, rdata, dout, din;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    asw_host asw_host_i (.core_clk_i(clk), .rst_i(rst), .req_i(req),
        .req_wr_i(req_wr), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
        .busy_o(busy), .done_o(done), .rdata_o(rdata),
        .sel_low_active_n_o(sel_n), .sel_high_active_o(sel_hi),
        .wr_strobe_n_o(wr_n), .out_gate_n_o(gate_n), .addr_o(addr),
        .data_o(dout), .data_oe_o(oe), .data_i(din));
    asw_sram_model asw_sram_model_i (.sel_n_i(sel_n), .sel_hi_i(sel_hi),
        .wr_n_i(wr_n), .gate_n_i(gate_n), .addr_i(addr), .wdata_i(dout),
        .rdata_o(din), .drv_o(drv));
    ////////////////////////////////////////////////////////////////////////
    // comparisons and closing report
    task automatic check8(input logic [ASW_DW-1:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t byte %h want %h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task give_verdict;
        if (n_fail == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // bus tasks: wait a bounded time, the done pulse is one cycle wide
    task automatic wait_done(input int n);
        int k;
        k = 0;
        while (done !== 1'b1 && k < 12) begin
            @(posedge clk);
            #1 k++;
        end
        check1(done === 1'b1 && busy === 1'b0 && k == n,
            "done late or early");
    endtask
    task automatic op(input logic w, input logic [ASW_AW-1:0] a,
                      input logic [ASW_DW-1:0] d);
        req = 1'b1;
        req_wr = w;
        req_addr = a;
        req_wdata = d;
        @(posedge clk);
        #1 req = 1'b0;
        check1(busy === 1'b1 && addr === a, "addr not set");
        wait_done(w ? 3 : 6);
        if (!w) check8(rdata, d);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // scenarios: back-to-back at both address ends, then overwrite
    task t_edges;
        op(1'b1, 13'h0000, 8'h3c);
        op(1'b1, 13'h1fff, 8'hc3);
        op(1'b1, 13'h0aaa, 8'h5a);
        op(1'b0, 13'h0000, 8'h3c);
        op(1'b0, 13'h1fff, 8'hc3);
        op(1'b0, 13'h0aaa, 8'h5a);
    endtask
    task t_overwrite;
        op(1'b1, 13'h0010, 8'ha5);
        op(1'b1, 13'h0011, 8'h96);
        op(1'b1, 13'h0010, 8'h0f);
        op(1'b0, 13'h0011, 8'h96);
        op(1'b0, 13'h0010, 8'h0f);
    endtask
    // a request held while busy must be ignored
    task t_refuse;
        op(1'b1, 13'h0300, 8'h22);
        req = 1'b1;
        req_addr = 13'h0200;
        req_wdata = 8'h11;
        @(posedge clk);
        #1 req_addr = 13'h0300;
        req_wdata = 8'h99;
        @(posedge clk);
        @(posedge clk);
        #1 req = 1'b0;
        wait_done(1);
        op(1'b0, 13'h0300, 8'h22);
        op(1'b0, 13'h0200, 8'h11);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // pin watch at the falling edge, where registered pins have settled
    always @(negedge clk) begin
        if (!rst) begin
            if (!wr_n) begin
                check1(gate_n && oe, "gate or oe off");
            end
            if (prev_sel && !sel_n && sel_hi) begin
                check1(addr === prev_addr, "addr moved");
            end
            check1(oe !== 1'b1 || drv !== 1'b1, "contention");
            prev_sel <= !sel_n && sel_hi;
            prev_addr <= addr;
        end else begin
            prev_sel <= 1'b0;
        end
    end
    // hang guard, far above the hundred or so cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            $display("BAD %0t timeout", $time);
            give_verdict();
        end
    end
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        req = 1'b0;
        req_wr = 1'b0;
        req_addr = 13'h0000;
        req_wdata = 8'h00;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        check1(sel_n && !sel_hi && wr_n && gate_n && !oe,
            "reset pins");
        t_edges();
        t_overwrite();
        t_refuse();
        give_verdict();
    end
endmodule
`default_nettype wire
